//--- rofm_host_model.sv
// Host side of the register port: one byte request at a time.
// Assumes requests are launched on the falling edge of the device clock.
`default_nettype none
`timescale 1ns/1ps

module rofm_host_model
   import rofm_pkg::*;
(
   // Clock
   input  wire logic       CLOCK,
   // Register port
   output var rofm_req_s   REG_REQ,
   input  wire logic [7:0] REG_RDATA,
   input  wire logic       REG_RVALID
);
   initial REG_REQ = '0;

   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge CLOCK);
      REG_REQ = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge CLOCK);
      // Released lines flip so a stale byte never passes for a live one
      REG_REQ = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask : write

   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge CLOCK);
      REG_REQ = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge CLOCK);
      d = REG_RDATA;
      v = REG_RVALID;
      REG_REQ = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
   endtask : read
endmodule : rofm_host_model
`default_nettype wire

//--- rofm_pkg.sv
// Package for the rail override and fault mask register bank.
// Assumes one device clock shared by the register port and the rail logic.
`default_nettype none

package rofm_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ROFM_OFF_FORCE_LEVEL = 8'ha1;
   localparam logic [7:0] ROFM_OFF_FAULT_MASK  = 8'ha2;

   // ****************************************************************
   // Field positions in the force-on / output level register
   // ****************************************************************
   localparam int ROFM_BIT_SMALL_LDO_THREE_FORCE_ON = 0;
   localparam int ROFM_BIT_SWITCH_B_ONE_FORCE_ON    = 1;
   localparam int ROFM_BIT_SHARED_RAIL_FORCE_ON     = 2;
   localparam int ROFM_BIT_TERMINATION_FORCE_ON     = 3;
   localparam int ROFM_BIT_OUT_PIN_ONE_LEVEL        = 4;
   localparam int ROFM_BIT_OUT_PIN_FOUR_LEVEL       = 7;

   // ****************************************************************
   // Field positions in the fault mask register
   // ****************************************************************
   localparam int ROFM_BIT_STEP_DOWN_ONE_FAULT_MASK = 0;
   localparam int ROFM_BIT_SWITCH_A_ONE_FAULT_MASK  = 6;
   localparam int ROFM_BIT_SMALL_LDO_TWO_FAULT_MASK = 7;

   // ****************************************************************
   // Variant defaults (first variant of the family)
   // ****************************************************************
   localparam logic [7:0] ROFM_RST_FORCE_LEVEL  = 8'h01;
   localparam logic [7:0] ROFM_RST_FAULT_MASK   = 8'hc0;
   localparam logic [3:0] ROFM_RST_PIN_IS_GP    = 4'h2;
   localparam logic [3:0] ROFM_RST_PIN_PUSHPULL = 4'h0;
   localparam logic       ROFM_RST_SHARED_IS_SW = 1'b0;

   // Register port request from the serial front end
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } rofm_req_s;

   // Layout of the force-on / output level register
   typedef struct packed {
      logic [3:0] level;
      logic [3:0] force_on;
   } rofm_ctrl_s;

endpackage : rofm_pkg

`default_nettype wire

//--- rofm_rail_ctl.sv
// Per-rail enable selection between host force-on and sequencing.
// Assumes all inputs come from logic on the device clock.
`default_nettype none
`timescale 1ns/1ps

module rofm_rail_ctl
   import rofm_pkg::*;
#(
   parameter int N = 4
)
(
   // Control
   input  wire logic [N-1:0] force_on,
   input  wire logic [N-1:0] disable_bit,
   input  wire logic [N-1:0] seq_en,
   // Result
   output logic      [N-1:0] rail_en
);

   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_rail
         // A forced rail stays off while its disable bit reads 0
         assign rail_en[i] = force_on[i] ? disable_bit[i] : seq_en[i];
      end
   endgenerate

endmodule : rofm_rail_ctl

`default_nettype wire

//--- rofm_regs.sv
// Rail force-on / output level register and first fault mask register.
// Assumes a register port from the serial front end on the same clock,
// and sequencing, disable and fault signals from on-chip logic.
//
// How it works
// - Pin four level bit drives it open-drain: 0 pulls low, 1 releases.
// - Bits 6, 5, 4 set levels of pins three, two, one when general outputs.
// - Pins not configured as general outputs follow power-good tree; level bit resets 0.
// - Bit 3 forces termination LDO on unless its disable bit is 0.
// - Bit 2 forces the shared rail, switch B2 or small LDO one, by variant.
// - Bit 1 forces load switch B1 on unless its disable bit is 0.
// - Bit 0 forces small LDO three on unless its disable bit is 0.
// - With force-on clear, a rail follows only its sequencing enable.
// - Fault mask bit 1 blocks that rail's fault from shutdown; 0 lets it through.
// - Mask bit 7 is small LDO two, bit 6 load switch A1.
// - Mask bits 5 to 0 are step-down rails six to one.
// - Force/level register at A1h, all bits read/write, variant reset.
// - Fault mask register at A2h, all bits read/write, variant reset.
`default_nettype none
`timescale 1ns/1ps

module rofm_regs
   import rofm_pkg::*;
#(
   parameter logic [7:0] FORCE_LEVEL_RESET = ROFM_RST_FORCE_LEVEL,
   parameter logic [7:0] FAULT_MASK_RESET  = ROFM_RST_FAULT_MASK,
   parameter logic [3:0] PIN_IS_GP         = ROFM_RST_PIN_IS_GP,
   parameter logic [3:0] PIN_PUSHPULL      = ROFM_RST_PIN_PUSHPULL,
   parameter logic       SHARED_IS_SWITCH  = ROFM_RST_SHARED_IS_SW
)
(
   // Clock and reset
   input  wire logic       CLOCK,
   input  wire logic       NRST,
   // Register port
   input  wire rofm_req_s  REG_REQ,
   output logic      [7:0] REG_RDATA,
   output logic            REG_RVALID,
   // Rail control
   input  wire logic [3:0] RAIL_SEQ_EN,
   input  wire logic [3:0] RAIL_DISABLE,
   output logic      [4:0] RAIL_EN,
   // Faults
   input  wire logic [7:0] RAIL_FAULT,
   output logic            SHUTDOWN_REQ,
   // Output pins
   input  wire logic [3:0] PIN_POWER_GOOD,
   output logic      [3:0] OUT_PIN_O,
   output logic      [3:0] OUT_PIN_OE
);

   // Level bits of pins that are not general outputs come up as 0
   localparam logic [7:0] CTRL_RESET = FORCE_LEVEL_RESET & {PIN_IS_GP, 4'hf};
   // Pin four has no push-pull option
   localparam logic [3:0] PUSHPULL   = PIN_PUSHPULL & 4'h7;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // ****************************************************************
   // Register file
   // ****************************************************************
   rofm_ctrl_s ctrl_reg;
   rofm_ctrl_s ctrl_next;
   logic [7:0] mask_reg;
   logic [7:0] mask_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       rvalid_reg;
   logic       rvalid_next;

   always_comb
   begin
      ctrl_next   = ctrl_reg;
      mask_next   = mask_reg;
      rdata_next  = rdata_reg;
      rvalid_next = REG_REQ.rd;
      if (REG_REQ.wr && hit(REG_REQ.addr, ROFM_OFF_FORCE_LEVEL))
      begin
         ctrl_next = REG_REQ.wdata;
      end
      if (REG_REQ.wr && hit(REG_REQ.addr, ROFM_OFF_FAULT_MASK))
      begin
         mask_next = REG_REQ.wdata;
      end
      // Reads see the value before a write in the same cycle
      if (REG_REQ.rd)
      begin
         if (hit(REG_REQ.addr, ROFM_OFF_FORCE_LEVEL))
         begin
            rdata_next = ctrl_reg;
         end
         else if (hit(REG_REQ.addr, ROFM_OFF_FAULT_MASK))
         begin
            rdata_next = mask_reg;
         end
         else
         begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (!NRST)
      begin
         ctrl_reg   <= CTRL_RESET;
         mask_reg   <= FAULT_MASK_RESET;
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg   <= ctrl_next;
         mask_reg   <= mask_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign REG_RDATA  = rdata_reg;
   assign REG_RVALID = rvalid_reg;

   // ****************************************************************
   // Rail enables
   // ****************************************************************
   logic [3:0] rail_sel;
   logic [4:0] rail_en_reg;
   logic [4:0] rail_en_next;

   rofm_rail_ctl #(
      .N (4)
   ) rofm_rail_ctl_i (
      .force_on    (ctrl_reg.force_on),
      .disable_bit (RAIL_DISABLE),
      .seq_en      (RAIL_SEQ_EN),
      .rail_en     (rail_sel)
   );

   always_comb
   begin
      rail_en_next    = {1'b0, rail_sel};
      // One override bit, routed to the rail this variant shares it with
      rail_en_next[2] = SHARED_IS_SWITCH ? rail_sel[2] : 1'b0;
      rail_en_next[4] = SHARED_IS_SWITCH ? 1'b0 : rail_sel[2];
   end

   // ****************************************************************
   // Fault shutdown and output pins
   // ****************************************************************
   logic       shut_reg;
   logic       shut_next;
   logic [3:0] pin_o_reg;
   logic [3:0] pin_o_next;
   logic [3:0] pin_oe_reg;
   logic [3:0] pin_oe_next;
   logic [3:0] pin_val;

   always_comb
   begin
      shut_next = |(RAIL_FAULT & ~mask_reg);
      pin_val   = (PIN_IS_GP & ctrl_reg.level) | (~PIN_IS_GP & PIN_POWER_GOOD);
      // Open-drain pins only ever pull low
      pin_o_next  = PUSHPULL & pin_val;
      pin_oe_next = PUSHPULL | ~pin_val;
   end

   always_ff @(posedge CLOCK)
   begin
      if (!NRST)
      begin
         rail_en_reg <= 5'h00;
         shut_reg    <= 1'b0;
         pin_o_reg   <= 4'h0;
         pin_oe_reg  <= 4'h0;
      end
      else
      begin
         rail_en_reg <= rail_en_next;
         shut_reg    <= shut_next;
         pin_o_reg   <= pin_o_next;
         pin_oe_reg  <= pin_oe_next;
      end
   end

   assign RAIL_EN      = rail_en_reg;
   assign SHUTDOWN_REQ = shut_reg;
   assign OUT_PIN_O    = pin_o_reg;
   assign OUT_PIN_OE   = pin_oe_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);

   a_ctrl_write: assert property ($past(NRST) && REG_REQ.wr && REG_REQ.addr == ROFM_OFF_FORCE_LEVEL
      |=> ctrl_reg == $past(REG_REQ.wdata)) else $error("force/level write lost");
   a_mask_write: assert property (REG_REQ.wr && REG_REQ.addr == ROFM_OFF_FAULT_MASK
      |=> mask_reg == $past(REG_REQ.wdata)) else $error("fault mask write lost");
   a_read_back: assert property (REG_REQ.rd && REG_REQ.addr == ROFM_OFF_FAULT_MASK
      |=> REG_RVALID && REG_RDATA == $past(mask_reg)) else $error("mask read mismatch");
   a_termination_force: assert property ($past(NRST) && ctrl_reg.force_on[3]
      |=> RAIL_EN[3] == $past(RAIL_DISABLE[3])) else $error("termination force wrong");
   a_switch_b1_force: assert property ($past(NRST) && ctrl_reg.force_on[1]
      |=> RAIL_EN[1] == $past(RAIL_DISABLE[1])) else $error("switch B1 force wrong");
   a_ldo_three_force: assert property ($past(NRST) && ctrl_reg.force_on[0]
      |=> RAIL_EN[0] == $past(RAIL_DISABLE[0])) else $error("LDO three force wrong");
   a_seq_follow: assert property ($past(NRST) && !ctrl_reg.force_on[3] && !ctrl_reg.force_on[1]
      |=> RAIL_EN[3] == $past(RAIL_SEQ_EN[3]) && RAIL_EN[1] == $past(RAIL_SEQ_EN[1]))
      else $error("unforced rail ignored sequencing");
   // The shared bit must reach the selected rail, not merely avoid the other one
   a_shared_route: assert property ($past(NRST) && ctrl_reg.force_on[2]
      |=> RAIL_EN[SHARED_IS_SWITCH ? 2 : 4] == $past(RAIL_DISABLE[2]))
      else $error("shared override misrouted");
   a_shared_unused: assert property ($past(NRST) |-> !RAIL_EN[SHARED_IS_SWITCH ? 4 : 2])
      else $error("shared override reached unselected rail");
   a_fault_shut: assert property ($past(NRST) |-> SHUTDOWN_REQ == $past(|(RAIL_FAULT & ~mask_reg)))
      else $error("fault shutdown mismatch");
   a_pin_four_od: assert property ($past(NRST) |-> !OUT_PIN_O[3])
      else $error("pin four driven high");
   a_pin_level: assert property ($past(NRST) && PIN_IS_GP[1]
      |=> OUT_PIN_OE[1] == (PUSHPULL[1] | !$past(ctrl_reg.level[1])))
      else $error("pin two level mismatch");
   a_pin_power_good: assert property ($past(NRST) && !PIN_IS_GP[0]
      |=> OUT_PIN_OE[0] == (PUSHPULL[0] | !$past(PIN_POWER_GOOD[0])))
      else $error("pin one ignores power-good tree");

   c_force_on: cover property (ctrl_reg.force_on[3] && RAIL_DISABLE[3] ##1 RAIL_EN[3]);
   c_shutdown: cover property (!SHUTDOWN_REQ ##1 SHUTDOWN_REQ);
   c_masked_fault: cover property (|(RAIL_FAULT & mask_reg) && !(|(RAIL_FAULT & ~mask_reg)));
   c_read: cover property (REG_REQ.rd && REG_REQ.addr == ROFM_OFF_FORCE_LEVEL ##1 REG_RVALID);

endmodule : rofm_regs

`default_nettype wire

//--- test_rail_override_fault_mask_regs.sv
// Self-checking bench for the rail override and fault mask registers.
// Assumes the default variant parameters of the register block.
`default_nettype none
`timescale 1ns/1ps

module test_rail_override_fault_mask_regs
   import rofm_pkg::*;
;
   logic       CLOCK = 1'b0;
   logic       NRST  = 1'b0;
   rofm_req_s  req;
   logic [7:0] rdata;
   logic       rvalid;
   logic [3:0] seq = '0, dis = '0, pwr_good = '0;
   logic [4:0] en;
   logic [7:0] fault = '0;
   logic       shut;
   logic [3:0] pin_o, pin_oe;
   int         num_errors = 0, total_checks = 0;

   always #5 CLOCK = ~CLOCK;

   rofm_host_model rofm_host_model_i (.CLOCK(CLOCK), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid));
   rofm_regs rofm_regs_i (.CLOCK(CLOCK), .NRST(NRST), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .RAIL_SEQ_EN(seq), .RAIL_DISABLE(dis), .RAIL_EN(en), .RAIL_FAULT(fault), .SHUTDOWN_REQ(shut),
      .PIN_POWER_GOOD(pwr_good), .OUT_PIN_O(pin_o), .OUT_PIN_OE(pin_oe));

   // ****
   // Shared checks
   // ****
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      rofm_host_model_i.read(a, d, v);
      chk("read valid", 8'h01, {7'h00, v});
      chk("read data", exp, d);
   endtask : rdchk

   // Outputs are registered one cycle behind their causes
   task automatic settle();
      repeat (2) @(negedge CLOCK);
   endtask : settle

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      settle();
      chk("rail enables", 8'h00, {3'h0, en});
      chk("pin oe", 8'h0f, {4'h0, pin_oe});
      rdchk(ROFM_OFF_FORCE_LEVEL, 8'h01);
      rdchk(ROFM_OFF_FAULT_MASK, 8'hc0);
      rdchk(8'ha3, 8'h00);
      // A write to an unmapped offset must land in neither register
      rofm_host_model_i.write(8'ha3, 8'hff);
      rdchk(ROFM_OFF_FORCE_LEVEL, 8'h01);
      rdchk(ROFM_OFF_FAULT_MASK, 8'hc0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_force();
      logic [3:0] fv [4] = '{4'h0, 4'hf, 4'h5, 4'ha};
      logic [3:0] r;
      for (int k = 0; k < 4; k++)
      begin
         rofm_host_model_i.write(ROFM_OFF_FORCE_LEVEL, {4'h0, fv[k]});
         rdchk(ROFM_OFF_FORCE_LEVEL, {4'h0, fv[k]});
         for (int j = 0; j < 4; j++)
         begin
            dis = 4'(3 * j + 5);
            seq = 4'(7 * j + 1);
            r = (fv[k] & dis) | (~fv[k] & seq);
            settle();
            chk("rail enables", {3'h0, r[2], r[3], 1'b0, r[1], r[0]}, {3'h0, en});
         end
      end
      $display("test force done");
   endtask : t_force

   task automatic t_fault();
      logic [7:0] mv [2] = '{8'h5a, 8'ha5};
      for (int k = 0; k < 2; k++)
      begin
         rofm_host_model_i.write(ROFM_OFF_FAULT_MASK, mv[k]);
         rdchk(ROFM_OFF_FAULT_MASK, mv[k]);
         for (int i = 0; i < 8; i++)
         begin
            fault = 8'h01 << i;
            settle();
            chk("shutdown", {7'h00, ~mv[k][i]}, {7'h00, shut});
         end
      end
      fault = '0;
      $display("test fault done");
   endtask : t_fault

   task automatic t_pins();
      pwr_good = 4'b0101;
      rofm_host_model_i.write(ROFM_OFF_FORCE_LEVEL, 8'hd0);
      settle();
      chk("pin oe", 8'h0a, {4'h0, pin_oe});
      chk("pin o", 8'h00, {4'h0, pin_o});
      rdchk(ROFM_OFF_FORCE_LEVEL, 8'hd0);
      pwr_good = 4'b1010;
      rofm_host_model_i.write(ROFM_OFF_FORCE_LEVEL, 8'h20);
      settle();
      chk("pin oe", 8'h05, {4'h0, pin_oe});
      chk("pin o", 8'h00, {4'h0, pin_o});
      $display("test pins done");
   endtask : t_pins

   initial
   begin
      repeat (6) @(negedge CLOCK);
      NRST = 1'b1;
      t_reset();
      t_force();
      t_fault();
      t_pins();
      wrap_up();
   end

   // The tests need well under a thousand cycles
   initial
   begin
      #50000;
      num_errors++;
      wrap_up();
   end
endmodule : test_rail_override_fault_mask_regs
`default_nettype wire
